// [core/dpsc_map.svh]
// register indices, field positions and reset values of the synthesizer control block
`ifndef DPSC_MAP_SVH
`define DPSC_MAP_SVH
`define DPSC_IDX_SRX      10'h081
`define DPSC_IDX_HYS_LO   10'h082
`define DPSC_IDX_CTRL     10'h083
`define DPSC_IDX_STAT     10'h084
`define DPSC_IDX_INT      10'h085
`define DPSC_IDX_LF1      10'h087
`define DPSC_IDX_DIVSEL   10'h08b
`define DPSC_IDX_REFCFG   10'h08c
`define DPSC_IDX_IRQ_ST   10'h090
`define DPSC_IDX_IRQ_EN   10'h091
`define DPSC_IDX_IRQ_CLR  10'h092
`define DPSC_RST_SRX      8'h10
`define DPSC_RST_INT      8'h06
`define DPSC_RST_LF1      8'h88
`define DPSC_RST_REFCFG   8'h08
`define DPSC_FB_MIN       8'h06
`define DPSC_BIT_PD       4
`define DPSC_BIT_EDGE     2
`define DPSC_BIT_RECAL    7
`define DPSC_BIT_EN       4
`define DPSC_BIT_PCAL_EN  3
`define DPSC_HYS_STEP_MV  7'h0a
`define DPSC_RESP_OKAY    2'h0
`define DPSC_RESP_SLVERR  2'h2
`endif

// [core/dpsc_pkg.sv]
// types shared by the synthesizer control block
package dpsc_pkg;
  // analog synthesizer status flags
  typedef struct packed {
    logic over_high;
    logic over_low;
    logic cal_valid;
    logic osc_cal;
    logic bias_ok;
    logic locked;
  } dpsc_stat_s;
  // write channel states
  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP    = 2'h2
  } dpsc_wr_e;
  // read channel states
  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } dpsc_rd_e;
endpackage

// [core/dpsc_ctrl.sv]
// synthesizer and sync reference control registers behind an axi4-lite slave
`timescale 1ns/1ns
`include "dpsc_map.svh"

module dpsc_ctrl #(
  parameter int ADDR_W = 12
) (
  input  wire logic                ACLK_UNUSED_IN,
  input  wire logic                CORE_CLK_IN,
  input  wire logic                RST_B_IN,
  input  wire logic [ADDR_W-1:0]   AWADDR_IN,
  input  wire logic                AWVALID_IN,
  output logic                     AWREADY_OUT,
  input  wire logic [31:0]         WDATA_IN,
  input  wire logic [3:0]          WSTRB_IN,
  input  wire logic                WVALID_IN,
  output logic                     WREADY_OUT,
  output logic [1:0]               BRESP_OUT,
  output logic                     BVALID_OUT,
  input  wire logic                BREADY_IN,
  input  wire logic [ADDR_W-1:0]   ARADDR_IN,
  input  wire logic                ARVALID_IN,
  output logic                     ARREADY_OUT,
  output logic [31:0]              RDATA_OUT,
  output logic [1:0]               RRESP_OUT,
  output logic                     RVALID_OUT,
  input  wire logic                RREADY_IN,
  input  wire dpsc_pkg::dpsc_stat_s SYNTH_STAT_IN,
  input  wire logic                SYNC_REF_IN,
  output logic                     SYNC_SAMPLED_OUT,
  output logic                     SYNC_PD_OUT,
  output logic                     SYNC_HYS_ON_OUT,
  output logic [9:0]               SYNC_HYS_CODE_OUT,
  output logic [6:0]               SYNC_HYS_MV_OUT,
  output logic                     SYNTH_EN_OUT,
  output logic                     CAL_START_OUT,
  output logic                     PUMP_CAL_EN_OUT,
  output logic [7:0]               FB_DIV_OUT,
  output logic [2:0]               REF_DIV_OUT,
  output logic [1:0]               OSC_DIV_SEL_OUT,
  output logic [4:0]               OSC_RATIO_OUT,
  output logic [8:0]               CONV_MULT_OUT,
  output logic [12:0]              OSC_MULT_OUT,
  output logic [7:0]               LOOP_FILT_OUT,
  output logic                     IRQ_OUT
);

  // refuse an address bus too narrow for the map
  if (ADDR_W < 12) begin : g_chk
    $error("ADDR_W must be at least 12");
  end

  dpsc_pkg::dpsc_wr_e   wr_st_ff;
  dpsc_pkg::dpsc_rd_e   rd_st_ff;
  dpsc_pkg::dpsc_stat_s stat_ff;
  dpsc_pkg::dpsc_stat_s stat_d_ff;
  logic                 aw_hold_ff;
  logic                 w_hold_ff;
  logic [9:0]           aw_idx_ff;
  logic [7:0]           wdat_ff;
  logic                 wlane_ff;
  logic                 wr_go;
  logic                 wr_hit;
  logic [7:0]           srx_ff;
  logic [7:0]           hys_lo_ff;
  logic [7:0]           ctrl_ff;
  logic [1:0]           stat_rsv_ff;
  logic [7:0]           int_ff;
  logic [7:0]           lf1_ff;
  logic [1:0]           divsel_ff;
  logic [7:0]           refcfg_ff;
  logic [3:0]           irq_st_ff;
  logic [3:0]           irq_en_ff;
  logic [3:0]           irq_set;
  logic [3:0]           irq_clr;
  logic                 recal_d_ff;
  logic                 en_d_ff;
  logic                 sync_fall_ff;
  logic                 sync_rise_ff;
  logic [8:0]           rd_word;
  logic [8:0]           wr_word;

  // oscillator to converter division ratio
  function automatic logic [4:0] osc_ratio(input logic [1:0] sel);
    logic [4:0] r;
    r = 5'h04;
    case (sel)
      2'h2:    r = 5'h08;
      2'h3:    r = 5'h10;
      default: r = 5'h04;
    endcase
    return r;
  endfunction

  // feedback divider with floor at the minimum
  function automatic logic [7:0] fb_eff(input logic [7:0] w);
    return (w < `DPSC_FB_MIN) ? `DPSC_FB_MIN : w;
  endfunction

  // status byte as software sees it
  function automatic logic [7:0] stat_byte(input dpsc_pkg::dpsc_stat_s s,
                                          input logic [1:0] rsv,
                                          input logic pcal_en);
    return {s.over_high, s.over_low, s.cal_valid & pcal_en, s.osc_cal,
            s.bias_ok, rsv[1], s.locked, rsv[0]};
  endfunction

  // register index decode, bit 8 flags a mapped index
  function automatic logic [8:0] rd_mux(input logic [9:0] idx);
    logic [8:0] r;
    r = 9'h000;
    if (idx == `DPSC_IDX_SRX) begin
      r = {1'b1, srx_ff};
    end else if (idx == `DPSC_IDX_HYS_LO) begin
      r = {1'b1, hys_lo_ff};
    end else if (idx == `DPSC_IDX_CTRL) begin
      r = {1'b1, ctrl_ff};
    end else if (idx == `DPSC_IDX_STAT) begin
      r = {1'b1, stat_byte(stat_ff, stat_rsv_ff, refcfg_ff[`DPSC_BIT_PCAL_EN])};
    end else if (idx == `DPSC_IDX_INT) begin
      r = {1'b1, int_ff};
    end else if (idx == `DPSC_IDX_LF1) begin
      r = {1'b1, lf1_ff};
    end else if (idx == `DPSC_IDX_DIVSEL) begin
      r = {1'b1, 6'h00, divsel_ff};
    end else if (idx == `DPSC_IDX_REFCFG) begin
      r = {1'b1, refcfg_ff};
    end else if (idx == `DPSC_IDX_IRQ_ST) begin
      r = {1'b1, 4'h0, irq_st_ff};
    end else if (idx == `DPSC_IDX_IRQ_EN) begin
      r = {1'b1, 4'h0, irq_en_ff};
    end else if (idx == `DPSC_IDX_IRQ_CLR) begin
      r = {1'b1, 8'h00};
    end
    return r;
  endfunction

  // write commit once address and data are both held
  assign wr_go  = aw_hold_ff & w_hold_ff & (wr_st_ff == dpsc_pkg::WR_COLLECT);
  // decodes in a process so register changes re-run them
  always_comb begin
    wr_word = rd_mux(aw_idx_ff);
    rd_word = rd_mux(ARADDR_IN[11:2]);
  end
  assign wr_hit = wr_word[8];

  // write address and data capture, either order
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      aw_hold_ff  <= 1'b0;
      w_hold_ff   <= 1'b0;
      aw_idx_ff   <= 10'h000;
      wdat_ff     <= 8'h00;
      wlane_ff    <= 1'b0;
      AWREADY_OUT <= 1'b1;
      WREADY_OUT  <= 1'b1;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_hold_ff  <= 1'b1;
        aw_idx_ff   <= AWADDR_IN[11:2];
        AWREADY_OUT <= 1'b0;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_hold_ff  <= 1'b1;
        wdat_ff    <= WDATA_IN[7:0];
        wlane_ff   <= WSTRB_IN[0];
        WREADY_OUT <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
      end
      if (BVALID_OUT && BREADY_IN) begin
        AWREADY_OUT <= 1'b1;
        WREADY_OUT  <= 1'b1;
      end
    end
  end

  // write response channel
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_st_ff   <= dpsc_pkg::WR_COLLECT;
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= `DPSC_RESP_OKAY;
    end else begin
      case (wr_st_ff)
        dpsc_pkg::WR_COLLECT: begin
          if (wr_go) begin
            BVALID_OUT <= 1'b1;
            BRESP_OUT  <= wr_hit ? `DPSC_RESP_OKAY : `DPSC_RESP_SLVERR;
            wr_st_ff   <= dpsc_pkg::WR_RESP;
          end
        end
        dpsc_pkg::WR_RESP: begin
          if (BREADY_IN) begin
            BVALID_OUT <= 1'b0;
            wr_st_ff   <= dpsc_pkg::WR_COLLECT;
          end
        end
        default: wr_st_ff <= dpsc_pkg::WR_COLLECT;
      endcase
    end
  end

  // read channel
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rd_st_ff    <= dpsc_pkg::RD_IDLE;
      ARREADY_OUT <= 1'b1;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0000_0000;
      RRESP_OUT   <= `DPSC_RESP_OKAY;
    end else begin
      case (rd_st_ff)
        dpsc_pkg::RD_IDLE: begin
          if (ARVALID_IN) begin
            ARREADY_OUT <= 1'b0;
            RVALID_OUT  <= 1'b1;
            RDATA_OUT   <= {24'h00_0000, rd_word[7:0]};
            RRESP_OUT   <= rd_word[8] ? `DPSC_RESP_OKAY : `DPSC_RESP_SLVERR;
            rd_st_ff    <= dpsc_pkg::RD_DATA;
          end
        end
        dpsc_pkg::RD_DATA: begin
          if (RREADY_IN) begin
            RVALID_OUT  <= 1'b0;
            ARREADY_OUT <= 1'b1;
            rd_st_ff    <= dpsc_pkg::RD_IDLE;
          end
        end
        default: rd_st_ff <= dpsc_pkg::RD_IDLE;
      endcase
    end
  end

  // software writable registers, low byte lane only
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      srx_ff      <= `DPSC_RST_SRX;
      hys_lo_ff   <= 8'h00;
      ctrl_ff     <= 8'h00;
      stat_rsv_ff <= 2'h0;
      int_ff      <= `DPSC_RST_INT;
      lf1_ff      <= `DPSC_RST_LF1;
      divsel_ff   <= 2'h0;
      refcfg_ff   <= `DPSC_RST_REFCFG;
      irq_en_ff   <= 4'h0;
    end else if (wr_go && wlane_ff) begin
      if (aw_idx_ff == `DPSC_IDX_SRX) begin
        srx_ff <= wdat_ff;
      end else if (aw_idx_ff == `DPSC_IDX_HYS_LO) begin
        hys_lo_ff <= wdat_ff;
      end else if (aw_idx_ff == `DPSC_IDX_CTRL) begin
        ctrl_ff <= wdat_ff;
      end else if (aw_idx_ff == `DPSC_IDX_STAT) begin
        stat_rsv_ff <= {wdat_ff[2], wdat_ff[0]};
      end else if (aw_idx_ff == `DPSC_IDX_INT) begin
        int_ff <= wdat_ff;
      end else if (aw_idx_ff == `DPSC_IDX_LF1) begin
        lf1_ff <= wdat_ff;
      end else if (aw_idx_ff == `DPSC_IDX_DIVSEL) begin
        divsel_ff <= wdat_ff[1:0];
      end else if (aw_idx_ff == `DPSC_IDX_REFCFG) begin
        refcfg_ff <= wdat_ff;
      end else if (aw_idx_ff == `DPSC_IDX_IRQ_EN) begin
        irq_en_ff <= wdat_ff[3:0];
      end
    end
  end

  // synthesizer status capture and edge history
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      stat_ff   <= '0;
      stat_d_ff <= '0;
    end else begin
      stat_ff   <= SYNTH_STAT_IN;
      stat_d_ff <= stat_ff;
    end
  end

  // events: over high, over low, lock lost, oscillator calibration done
  assign irq_set = {stat_d_ff.osc_cal & ~stat_ff.osc_cal,
                    stat_d_ff.locked & ~stat_ff.locked,
                    stat_ff.over_low & ~stat_d_ff.over_low,
                    stat_ff.over_high & ~stat_d_ff.over_high};
  assign irq_clr = (wr_go && wlane_ff && aw_idx_ff == `DPSC_IDX_IRQ_CLR) ?
                   wdat_ff[3:0] : 4'h0;

  // sticky event bits, set beats clear
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      irq_st_ff <= 4'h0;
      IRQ_OUT   <= 1'b0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
      IRQ_OUT   <= |(irq_st_ff & irq_en_ff);
    end
  end

  // calibration launch on enable or recalibrate rising edges
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      recal_d_ff    <= 1'b0;
      en_d_ff       <= 1'b0;
      CAL_START_OUT <= 1'b0;
      SYNTH_EN_OUT  <= 1'b0;
    end else begin
      recal_d_ff    <= ctrl_ff[`DPSC_BIT_RECAL];
      en_d_ff       <= ctrl_ff[`DPSC_BIT_EN];
      CAL_START_OUT <= (ctrl_ff[`DPSC_BIT_RECAL] & ~recal_d_ff) |
                       (ctrl_ff[`DPSC_BIT_EN] & ~en_d_ff);
      SYNTH_EN_OUT  <= ctrl_ff[`DPSC_BIT_EN];
    end
  end

  // sync reference sampled on the falling edge
  always_ff @(negedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sync_fall_ff <= 1'b0;
    end else begin
      sync_fall_ff <= SYNC_REF_IN;
    end
  end

  // sync reference sampled on the rising edge, then edge choice
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sync_rise_ff     <= 1'b0;
      SYNC_SAMPLED_OUT <= 1'b0;
    end else begin
      sync_rise_ff     <= SYNC_REF_IN;
      SYNC_SAMPLED_OUT <= srx_ff[`DPSC_BIT_EDGE] ? sync_rise_ff : sync_fall_ff;
    end
  end

  // receiver and synthesizer settings driven out
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SYNC_PD_OUT       <= 1'b1;
      SYNC_HYS_ON_OUT   <= 1'b0;
      SYNC_HYS_CODE_OUT <= 10'h000;
      SYNC_HYS_MV_OUT   <= 7'h00;
      PUMP_CAL_EN_OUT   <= 1'b1;
      FB_DIV_OUT        <= `DPSC_FB_MIN;
      REF_DIV_OUT       <= 3'h0;
      OSC_DIV_SEL_OUT   <= 2'h0;
      OSC_RATIO_OUT     <= 5'h04;
      CONV_MULT_OUT     <= 9'h00c;
      OSC_MULT_OUT      <= 13'h0030;
      LOOP_FILT_OUT     <= `DPSC_RST_LF1;
    end else begin
      SYNC_PD_OUT       <= srx_ff[`DPSC_BIT_PD];
      SYNC_HYS_ON_OUT   <= srx_ff[3];
      SYNC_HYS_CODE_OUT <= {srx_ff[1:0], hys_lo_ff};
      SYNC_HYS_MV_OUT   <= 7'($countones({srx_ff[1:0], hys_lo_ff})) *
                           `DPSC_HYS_STEP_MV;
      PUMP_CAL_EN_OUT   <= refcfg_ff[`DPSC_BIT_PCAL_EN];
      FB_DIV_OUT        <= fb_eff(int_ff);
      REF_DIV_OUT       <= refcfg_ff[2:0];
      OSC_DIV_SEL_OUT   <= divsel_ff;
      OSC_RATIO_OUT     <= osc_ratio(divsel_ff);
      CONV_MULT_OUT     <= {fb_eff(int_ff), 1'b0};
      OSC_MULT_OUT      <= 13'({fb_eff(int_ff), 1'b0} * osc_ratio(divsel_ff));
      LOOP_FILT_OUT     <= lf1_ff;
    end
  end

endmodule

// [test/dpsc_ctrl_monitor.sv]
// port assertions for the synthesizer control block
`timescale 1ns/1ns
module dpsc_ctrl_monitor (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        RVALID_OUT,
  input  wire logic [31:0] RDATA_OUT,
  input  wire logic        SYNTH_EN_OUT,
  input  wire logic        CAL_START_OUT,
  input  wire logic [7:0]  FB_DIV_OUT,
  input  wire logic [8:0]  CONV_MULT_OUT,
  input  wire logic [1:0]  OSC_DIV_SEL_OUT,
  input  wire logic [4:0]  OSC_RATIO_OUT,
  input  wire logic [12:0] OSC_MULT_OUT,
  input  wire logic [9:0]  SYNC_HYS_CODE_OUT,
  input  wire logic [6:0]  SYNC_HYS_MV_OUT,
  input  wire logic        IRQ_OUT
);
  // one clock domain, reset disables all
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  a_cal_one_cycle: assert property (CAL_START_OUT |=> !CAL_START_OUT)
    else $error("calibration start pulse too long");
  a_enable_starts_cal: assert property ($rose(SYNTH_EN_OUT) |-> ##[0:2] CAL_START_OUT)
    else $error("enable did not start calibration");
  a_divider_floor: assert property (FB_DIV_OUT >= 8'h06)
    else $error("feedback divider below six");
  a_conv_double: assert property (CONV_MULT_OUT == {1'b0, FB_DIV_OUT} * 9'h002)
    else $error("converter multiple not twice divider");
  a_ratio_decode: assert property (OSC_RATIO_OUT == ((OSC_DIV_SEL_OUT == 2'h2) ? 5'h08 :
    (OSC_DIV_SEL_OUT == 2'h3) ? 5'h10 : 5'h04))
    else $error("oscillator ratio decode wrong");
  a_osc_product: assert property (OSC_MULT_OUT == 13'(FB_DIV_OUT) * 13'h002 * 13'(OSC_RATIO_OUT))
    else $error("oscillator multiple wrong");
  a_hys_millivolt: assert property (SYNC_HYS_MV_OUT == 7'($countones(SYNC_HYS_CODE_OUT) * 10))
    else $error("hysteresis millivolts wrong");
  a_rdata_narrow: assert property (RVALID_OUT |-> RDATA_OUT[31:8] == 24'h0)
    else $error("read data upper bits set");
  // main scenarios reached
  c_cal: cover property (CAL_START_OUT);
  c_irq: cover property (IRQ_OUT);
  c_div16: cover property (OSC_RATIO_OUT == 5'h10);
endmodule
bind dpsc_ctrl dpsc_ctrl_monitor dpsc_ctrl_monitor_i (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .RVALID_OUT(RVALID_OUT),
  .RDATA_OUT(RDATA_OUT), .SYNTH_EN_OUT(SYNTH_EN_OUT), .CAL_START_OUT(CAL_START_OUT),
  .FB_DIV_OUT(FB_DIV_OUT), .CONV_MULT_OUT(CONV_MULT_OUT), .OSC_DIV_SEL_OUT(OSC_DIV_SEL_OUT),
  .OSC_RATIO_OUT(OSC_RATIO_OUT), .OSC_MULT_OUT(OSC_MULT_OUT),
  .SYNC_HYS_CODE_OUT(SYNC_HYS_CODE_OUT), .SYNC_HYS_MV_OUT(SYNC_HYS_MV_OUT), .IRQ_OUT(IRQ_OUT));

// [test/tb.sv]
// self-checking bench for the synthesizer control block
`timescale 1ns/1ns
module tb;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, sync_ref;
  logic        awready, wready, bvalid, arready, rvalid, sampled, pd, synth_en;
  logic        cal_start, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [9:0]  hys_code;
  logic [6:0]  hys_mv;
  logic [7:0]  fb_div, loop_filt;
  logic        hys_on, pcal_en;
  logic [2:0]  ref_div;
  logic [1:0]  div_sel;
  logic [4:0]  osc_ratio;
  logic [8:0]  conv_mult;
  logic [12:0] osc_mult;
  dpsc_pkg::dpsc_stat_s stat;
  int          errors = 0, n_tests = 0, cal_n = 0;
  dpsc_ctrl dpsc_ctrl_i (.ACLK_UNUSED_IN(1'b0), .CORE_CLK_IN(clk), .RST_B_IN(rst_b),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
    .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
    .RREADY_IN(rready), .SYNTH_STAT_IN(stat), .SYNC_REF_IN(sync_ref),
    .SYNC_SAMPLED_OUT(sampled), .SYNC_PD_OUT(pd), .SYNC_HYS_ON_OUT(hys_on),
    .SYNC_HYS_CODE_OUT(hys_code), .SYNC_HYS_MV_OUT(hys_mv), .SYNTH_EN_OUT(synth_en),
    .CAL_START_OUT(cal_start), .PUMP_CAL_EN_OUT(pcal_en), .FB_DIV_OUT(fb_div),
    .REF_DIV_OUT(ref_div), .OSC_DIV_SEL_OUT(div_sel), .OSC_RATIO_OUT(osc_ratio),
    .CONV_MULT_OUT(conv_mult), .OSC_MULT_OUT(osc_mult), .LOOP_FILT_OUT(loop_filt),
    .IRQ_OUT(irq));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count calibration pulses
  always @(posedge clk) begin
    if (cal_start === 1'b1) cal_n <= cal_n + 1;
  end
  task automatic test_done;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // axi4-lite write, response checked
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (!aw && !w && bvalid === 1'b1) begin
        chk(32'(bresp), 32'(er));
        return;
      end
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    errors++;
    test_done();
  endtask
  // axi4-lite read, data and response checked
  task automatic rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic ar;
    ar = 1'b1;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end else if (!ar && rvalid === 1'b1) begin
        chk(rdata, {24'h0, ed});
        chk(32'(rresp), 32'(er));
        return;
      end
    end
    errors++;
    test_done();
  endtask
  // register and output reset values
  task automatic t_reset;
    logic [9:0] ix [8] = '{10'h081, 10'h082, 10'h083, 10'h084, 10'h085, 10'h087, 10'h08b, 10'h08c};
    logic [7:0] ev [8] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h06, 8'h88, 8'h00, 8'h08};
    for (int i = 0; i < 8; i++) rd(ix[i], ev[i], 2'h0);
    chk(32'(fb_div), 32'h6);
    chk(32'(osc_mult), 32'h30);
    chk(32'(pd), 32'h1);
    chk(32'(loop_filt), 32'h88);
    chk(32'(pcal_en), 32'h1);
  endtask
  // sync sampling in both edge modes, receiver powered
  task automatic t_sync;
    for (int e = 0; e < 2; e++) begin
      wr(10'h081, e ? 8'h04 : 8'h00, 2'h0);
      sync_ref <= 1'b1;
      idle(3);
      chk(32'(sampled), 32'h1);
      sync_ref <= 1'b0;
      idle(3);
      chk(32'(sampled), 32'h0);
    end
    chk(32'(pd), 32'h0);
  endtask
  // split hysteresis code and millivolts
  task automatic t_hys;
    wr(10'h081, 8'h09, 2'h0);
    wr(10'h082, 8'hff, 2'h0);
    idle(2);
    chk(32'(hys_code), 32'h1ff);
    chk(32'(hys_mv), 32'h5a);
    chk(32'(hys_on), 32'h1);
    rd(10'h081, 8'h09, 2'h0);
  endtask
  // calibration on rising edges only
  task automatic t_cal;
    int c;
    c = cal_n;
    wr(10'h083, 8'h80, 2'h0);
    idle(4);
    chk(cal_n, c + 1);
    wr(10'h083, 8'h80, 2'h0);
    idle(4);
    chk(cal_n, c + 1);
    wr(10'h083, 8'h00, 2'h0);
    wr(10'h083, 8'h10, 2'h0);
    idle(4);
    chk(cal_n, c + 2);
    chk(32'(synth_en), 32'h1);
  endtask
  // status flags, read-only bits and pump gating
  task automatic t_status;
    wr(10'h084, 8'hff, 2'h0);
    rd(10'h084, 8'h05, 2'h0);
    stat <= 6'h3f;
    idle(2);
    rd(10'h084, 8'hff, 2'h0);
    wr(10'h08c, 8'h00, 2'h0);
    rd(10'h084, 8'hdf, 2'h0);
    chk(32'(pcal_en), 32'h0);
    wr(10'h08c, 8'h0b, 2'h0);
    stat <= 6'h2a;
    idle(2);
    rd(10'h084, 8'had, 2'h0);
    stat <= 6'h15;
    idle(2);
    rd(10'h084, 8'h57, 2'h0);
    chk(32'(ref_div), 32'h3);
    chk(32'(pcal_en), 32'h1);
  endtask
  // sticky events, enable mask and clear
  task automatic t_irq;
    stat <= 6'h00;
    idle(4);
    rd(10'h090, 8'h0f, 2'h0);
    wr(10'h092, 8'h0f, 2'h0);
    rd(10'h090, 8'h00, 2'h0);
    wr(10'h091, 8'h01, 2'h0);
    stat <= 6'h20;
    idle(4);
    chk(32'(irq), 32'h1);
    wr(10'h091, 8'h00, 2'h0);
    idle(2);
    chk(32'(irq), 32'h0);
    wr(10'h092, 8'h01, 2'h0);
    rd(10'h090, 8'h00, 2'h0);
  endtask
  // divider floor, products and ratio select
  task automatic t_div;
    wr(10'h085, 8'h03, 2'h0);
    idle(2);
    chk(32'(fb_div), 32'h6);
    rd(10'h085, 8'h03, 2'h0);
    wr(10'h085, 8'h0a, 2'h0);
    wstrb <= 4'h0;
    wr(10'h085, 8'hff, 2'h0);
    wstrb <= 4'h1;
    rd(10'h085, 8'h0a, 2'h0);
    chk(32'(conv_mult), 32'h14);
    for (int s = 1; s < 4; s++) begin
      wr(10'h08b, 8'(s), 2'h0);
      idle(2);
      chk(32'(osc_ratio), 32'h2 << s);
      chk(32'(div_sel), 32'(s));
      chk(32'(osc_mult), 32'd40 << s);
    end
  endtask
  // unmapped place refused both ways
  task automatic t_unmapped;
    wr(10'h0ff, 8'h5a, 2'h2);
    rd(10'h0ff, 8'h00, 2'h2);
  endtask
  // reset, then scenarios in order
  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, arvalid, sync_ref} = 4'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    stat = 6'h00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_sync();
    t_hys();
    t_cal();
    t_status();
    t_irq();
    t_div();
    t_unmapped();
    test_done();
  end
endmodule
